/* File: hw/heos_pkg.sv */
// Operation
// - Fundamental active, reactive, apparent power each kept in a 24-bit signed register.
// - Each of three selected harmonics keeps its own three 24-bit power registers.
// - Fundamental power factor is active over apparent power, signed by reactive power.
// - Each selected harmonic power factor is active over apparent, signed by reactive.
// - Voltage and current distortion: root of total^2 minus fundamental^2, over fundamental.
// - Total distortion results kept as signed 3.21, clamped at the largest positive value.
// - Per harmonic, voltage and current ratios of harmonic rms over fundamental rms.
// - The six harmonic ratios kept as signed 3.21, clamped at the largest positive value.
// - Neutral mode puts neutral-current harmonic rms into the harmonic current-rms registers.
// - Neutral mode puts summed-current harmonic rms into the harmonic voltage-rms registers.
// - Neutral ratios over the fundamental only when first harmonic index holds one.
package heos_pkg;

	localparam int unsigned DW   = 24;
	localparam int unsigned FRAC = 21;
	localparam int unsigned NH   = 3;
	localparam int unsigned NRES = 30;
	localparam int unsigned AW   = 8;
	localparam int unsigned IW   = 6;

	localparam logic [DW-1:0] RATIO_MAX = 24'h7FFFFF;

	// ******************************************************
	// Register map
	// ******************************************************
	localparam logic [AW-1:0] ADDR_CTRL     = 8'h00;
	localparam logic [AW-1:0] ADDR_IDX_BASE = 8'h04;
	localparam logic [AW-1:0] ADDR_STATUS   = 8'h10;
	localparam logic [AW-1:0] ADDR_RES_BASE = 8'h40;

	localparam int unsigned CTRL_NEUTRAL_BIT = 0;
	localparam int unsigned STAT_BUSY_BIT    = 0;
	localparam int unsigned STAT_NDIST_BIT   = 1;
	localparam int unsigned STAT_MODE_BIT    = 2;

	localparam logic          CTRL_RST = 1'b0;
	localparam logic [IW-1:0] IDX_RST  = 6'h00;
	localparam logic [IW-1:0] IDX_FUND = 6'h01;

	// Result word indices
	localparam int unsigned RES_FUND_P  = 0;
	localparam int unsigned RES_HARM_P  = 3;
	localparam int unsigned RES_FPF     = 12;
	localparam int unsigned RES_HPF     = 13;
	localparam int unsigned RES_VOLTAGE_TOTAL_DISTORTION    = 16;
	localparam int unsigned RES_CURRENT_TOTAL_DISTORTION    = 17;
	localparam int unsigned RES_HVD     = 18;
	localparam int unsigned RES_HID     = 21;
	localparam int unsigned RES_HI_RMS  = 24;
	localparam int unsigned RES_HV_RMS  = 27;

	// Sequencer steps
	localparam logic [3:0] STEP_SQRT_V = 4'h0;
	localparam logic [3:0] STEP_SQRT_I = 4'h1;
	localparam logic [3:0] STEP_FPF    = 4'h2;
	localparam logic [3:0] STEP_HPF    = 4'h3;
	localparam logic [3:0] STEP_VOLTAGE_TOTAL_DISTORTION   = 4'h6;
	localparam logic [3:0] STEP_CURRENT_TOTAL_DISTORTION   = 4'h7;
	localparam logic [3:0] STEP_HVD    = 4'h8;
	localparam logic [3:0] STEP_HID    = 4'hB;
	localparam logic [3:0] STEP_LAST   = 4'hD;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_LAUNCH = 2'b01,
		ST_WAIT   = 2'b10
	} heos_state_t;

	typedef struct packed {
		logic [DW-1:0]         fund_p;
		logic [DW-1:0]         fund_q;
		logic [DW-1:0]         fund_s;
		logic [NH-1:0][DW-1:0] harm_p;
		logic [NH-1:0][DW-1:0] harm_q;
		logic [NH-1:0][DW-1:0] harm_s;
		logic [DW-1:0]         v_rms;
		logic [DW-1:0]         i_rms;
		logic [DW-1:0]         fund_v_rms;
		logic [DW-1:0]         fund_i_rms;
		logic [NH-1:0][DW-1:0] harm_v_rms;
		logic [NH-1:0][DW-1:0] harm_i_rms;
		logic [NH-1:0][DW-1:0] neutral_rms;
		logic [NH-1:0][DW-1:0] summed_phase_current;
	} heos_meas_t;

	typedef struct packed {
		logic [AW-1:0] awaddr;
		logic          awvalid;
		logic [31:0]   wdata;
		logic [3:0]    wstrb;
		logic          wvalid;
		logic          bready;
		logic [AW-1:0] araddr;
		logic          arvalid;
		logic          rready;
	} heos_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} heos_axil_rsp_t;

endpackage

/* File: hw/heos_divider.sv */
module heos_divider import heos_pkg::*; #(
	parameter int unsigned NW = DW,
	parameter int unsigned FW = FRAC
) (
	// Clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// Operands
	input  wire logic          start,
	input  wire logic [NW-1:0] num,
	input  wire logic [NW-1:0] den,
	// Result
	output logic               done,
	output logic [NW-1:0]      quo
);
	localparam int unsigned XW = NW + FW;
	localparam int unsigned IB = NW - 1 - FW;

	logic [XW-1:0] dvd_q;
	logic [XW-1:0] q_q;
	logic [NW:0]   rem_q;
	logic [NW-1:0] den_q;
	logic [6:0]    cnt_q;
	logic          busy_q;
	logic [NW:0]   rem_sh;
	logic [NW+IB:0] lim;

	assign rem_sh = {rem_q[NW-1:0], dvd_q[XW-1]};
	assign lim    = {{IB{1'b0}}, 1'b0, den} << IB;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_q <= 1'b0;
			done   <= 1'b0;
			quo    <= '0;
			dvd_q  <= '0;
			q_q    <= '0;
			rem_q  <= '0;
			den_q  <= '0;
			cnt_q  <= '0;
		end else begin
			done <= 1'b0;
			if (start) begin
				// Ratios of four or more, and a zero divisor, clamp at once
				if (den == '0 || {{(IB+1){1'b0}}, num} >= lim) begin
					quo  <= RATIO_MAX;
					done <= 1'b1;
				end else begin
					dvd_q  <= {num, {FW{1'b0}}};
					q_q    <= '0;
					rem_q  <= '0;
					den_q  <= den;
					cnt_q  <= 7'(XW);
					busy_q <= 1'b1;
				end
			end else if (busy_q) begin
				dvd_q <= dvd_q << 1;
				if (rem_sh >= {1'b0, den_q}) begin
					rem_q <= rem_sh - {1'b0, den_q};
					q_q   <= {q_q[XW-2:0], 1'b1};
				end else begin
					rem_q <= rem_sh;
					q_q   <= {q_q[XW-2:0], 1'b0};
				end
				cnt_q <= cnt_q - 7'd1;
				if (cnt_q == 7'd1) begin
					busy_q <= 1'b0;
				end
			end
			if (busy_q && cnt_q == 7'd1) begin
				done <= 1'b1;
				quo  <= rem_sh >= {1'b0, den_q} ? {q_q[NW-2:0], 1'b1} : {q_q[NW-2:0], 1'b0};
			end
		end
	end

endmodule // heos_divider

/* File: hw/heos_sqrt.sv */
module heos_sqrt import heos_pkg::*; #(
	parameter int unsigned RW = DW
) (
	// Clock and reset
	input  wire logic            aclk,
	input  wire logic            aresetn,
	// Operand
	input  wire logic            start,
	input  wire logic [2*RW-1:0] rad,
	// Result
	output logic                 done,
	output logic [RW-1:0]        root
);
	logic [2*RW-1:0] rad_q;
	logic [4:0]      bit_q;
	logic            busy_q;
	logic [RW-1:0]   trial;
	logic [2*RW-1:0] trial_sq;

	assign trial    = root | (RW'(1) << bit_q);
	assign trial_sq = {{RW{1'b0}}, trial} * {{RW{1'b0}}, trial};

	// One root bit per cycle; a multiplier is cheaper here than a second adder tree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rad_q  <= '0;
			bit_q  <= '0;
			busy_q <= 1'b0;
			done   <= 1'b0;
			root   <= '0;
		end else begin
			done <= 1'b0;
			if (start) begin
				rad_q  <= rad;
				root   <= '0;
				bit_q  <= 5'(RW - 1);
				busy_q <= 1'b1;
			end else if (busy_q) begin
				if (trial_sq <= rad_q) begin
					root <= trial;
				end
				bit_q <= bit_q - 5'd1;
				if (bit_q == '0) begin
					busy_q <= 1'b0;
					done   <= 1'b1;
				end
			end
		end
	end

endmodule // heos_sqrt

/* File: hw/heos_top.sv */
module heos_top import heos_pkg::*; (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Register bus
	input  wire heos_axil_req_t   axil_req,
	output heos_axil_rsp_t        axil_rsp,
	// Measurements from the rms and power datapaths
	input  wire heos_meas_t       meas,
	input  wire logic             meas_valid,
	output logic                  meas_ready,
	// Harmonic selection towards the datapaths
	output logic [NH-1:0][IW-1:0] harm_index,
	output logic                  neutral_mode
);

	// ******************************************************
	// Helpers
	// ******************************************************
	function automatic logic [DW-1:0] mag(input logic [DW-1:0] v);
		mag = v[DW-1] ? DW'(-v) : v;
	endfunction

	function automatic logic [2*DW-1:0] sq_diff(input logic [DW-1:0] tot,
			input logic [DW-1:0] fund);
		logic [2*DW-1:0] a;
		logic [2*DW-1:0] b;
		a = {{DW{1'b0}}, mag(tot)} * {{DW{1'b0}}, mag(tot)};
		b = {{DW{1'b0}}, mag(fund)} * {{DW{1'b0}}, mag(fund)};
		// Noise can push the total below the fundamental
		sq_diff = a > b ? a - b : '0;
	endfunction

	// ******************************************************
	// Control registers
	// ******************************************************
	logic                  ctrl_neutral_q;
	logic [NH-1:0][IW-1:0] idx_q;

	// ******************************************************
	// Sequencer state
	// ******************************************************
	heos_state_t     state_q;
	logic [3:0]      step_q;
	logic            mode_q;
	logic            ndist_q;
	heos_meas_t      snap_q;
	logic [DW-1:0]   root_v_q;
	logic [DW-1:0]   root_i_q;
	logic [DW-1:0]   res_q [NRES];
	logic            accept;
	logic            run_ndist;

	// Current operation
	logic            op_sqrt;
	logic [2*DW-1:0] op_rad;
	logic [DW-1:0]   op_num;
	logic [DW-1:0]   op_den;
	logic            op_neg;
	logic [4:0]      op_dest;
	logic [1:0]      k;

	// Arithmetic units
	logic            div_start;
	logic            div_done;
	logic [DW-1:0]   div_quo;
	logic            sqrt_start;
	logic            sqrt_done;
	logic [DW-1:0]   sqrt_root;
	logic            op_done;

	assign meas_ready   = state_q == ST_IDLE;
	assign accept       = meas_valid && meas_ready;
	assign harm_index   = idx_q;
	assign neutral_mode = ctrl_neutral_q;
	assign run_ndist    = idx_q[0] == IDX_FUND;
	assign div_start    = state_q == ST_LAUNCH && !op_sqrt;
	assign sqrt_start   = state_q == ST_LAUNCH && op_sqrt;
	assign op_done      = state_q == ST_WAIT && (op_sqrt ? sqrt_done : div_done);

	// ******************************************************
	// Operation select
	// ******************************************************
	always_comb begin
		op_sqrt = 1'b0;
		op_rad  = '0;
		op_num  = '0;
		op_den  = '0;
		op_neg  = 1'b0;
		op_dest = '0;
		k       = '0;
		case (step_q)
			STEP_SQRT_V: begin
				op_sqrt = 1'b1;
				op_rad  = sq_diff(snap_q.v_rms, snap_q.fund_v_rms);
			end
			STEP_SQRT_I: begin
				op_sqrt = 1'b1;
				op_rad  = sq_diff(snap_q.i_rms, snap_q.fund_i_rms);
			end
			STEP_FPF: begin
				op_num  = mag(snap_q.fund_p);
				op_den  = mag(snap_q.fund_s);
				op_neg  = snap_q.fund_p[DW-1] ^ snap_q.fund_q[DW-1];
				op_dest = 5'(RES_FPF);
			end
			4'h3, 4'h4, 4'h5: begin
				k       = 2'(step_q - STEP_HPF);
				op_num  = mag(snap_q.harm_p[k]);
				op_den  = mag(snap_q.harm_s[k]);
				op_neg  = snap_q.harm_p[k][DW-1] ^ snap_q.harm_q[k][DW-1];
				op_dest = 5'(RES_HPF + 32'(k));
			end
			STEP_VOLTAGE_TOTAL_DISTORTION: begin
				op_num  = root_v_q;
				op_den  = mag(snap_q.fund_v_rms);
				op_dest = 5'(RES_VOLTAGE_TOTAL_DISTORTION);
			end
			STEP_CURRENT_TOTAL_DISTORTION: begin
				op_num  = root_i_q;
				op_den  = mag(snap_q.fund_i_rms);
				op_dest = 5'(RES_CURRENT_TOTAL_DISTORTION);
			end
			4'h8, 4'h9, 4'hA: begin
				k       = 2'(step_q - STEP_HVD);
				op_dest = 5'(RES_HVD + 32'(k));
				if (mode_q) begin
					op_num = mag(snap_q.summed_phase_current[k]);
					op_den = mag(snap_q.summed_phase_current[0]);
				end else begin
					op_num = mag(snap_q.harm_v_rms[k]);
					op_den = mag(snap_q.fund_v_rms);
				end
			end
			4'hB, 4'hC, 4'hD: begin
				k       = 2'(step_q - STEP_HID);
				op_dest = 5'(RES_HID + 32'(k));
				if (mode_q) begin
					op_num = mag(snap_q.neutral_rms[k]);
					op_den = mag(snap_q.neutral_rms[0]);
				end else begin
					op_num = mag(snap_q.harm_i_rms[k]);
					op_den = mag(snap_q.fund_i_rms);
				end
			end
			default: begin
				op_sqrt = 1'b0;
			end
		endcase
	end

	// ******************************************************
	// Sequencer
	// ******************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			step_q  <= STEP_SQRT_V;
			mode_q  <= CTRL_RST;
			ndist_q <= 1'b0;
			snap_q  <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (accept) begin
						snap_q <= meas;
						mode_q <= ctrl_neutral_q;
						if (ctrl_neutral_q) begin
							// Neutral mode skips powers, factors and totals
							step_q  <= STEP_HVD;
							ndist_q <= run_ndist;
							state_q <= run_ndist ? ST_LAUNCH : ST_IDLE;
						end else begin
							step_q  <= STEP_SQRT_V;
							ndist_q <= 1'b0;
							state_q <= ST_LAUNCH;
						end
					end
				end
				ST_LAUNCH: begin
					state_q <= ST_WAIT;
				end
				ST_WAIT: begin
					if (op_done) begin
						if (step_q == STEP_LAST) begin
							state_q <= ST_IDLE;
						end else begin
							step_q  <= step_q + 4'd1;
							state_q <= ST_LAUNCH;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Roots of the harmonic energy, kept for the two total-distortion divides
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			root_v_q <= '0;
			root_i_q <= '0;
		end else if (op_done && op_sqrt) begin
			if (step_q == STEP_SQRT_V) begin
				root_v_q <= sqrt_root;
			end else begin
				root_i_q <= sqrt_root;
			end
		end
	end

	// ******************************************************
	// Result registers
	// ******************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NRES; i++) begin
				res_q[i] <= '0;
			end
		end else begin
			if (accept) begin
				for (int h = 0; h < NH; h++) begin
					if (ctrl_neutral_q) begin
						res_q[RES_HI_RMS + h] <= meas.neutral_rms[h];
						res_q[RES_HV_RMS + h] <= meas.summed_phase_current[h];
					end else begin
						res_q[RES_HARM_P + 3*h]     <= meas.harm_p[h];
						res_q[RES_HARM_P + 3*h + 1] <= meas.harm_q[h];
						res_q[RES_HARM_P + 3*h + 2] <= meas.harm_s[h];
						res_q[RES_HI_RMS + h]       <= meas.harm_i_rms[h];
						res_q[RES_HV_RMS + h]       <= meas.harm_v_rms[h];
					end
				end
				if (!ctrl_neutral_q) begin
					res_q[RES_FUND_P]     <= meas.fund_p;
					res_q[RES_FUND_P + 1] <= meas.fund_q;
					res_q[RES_FUND_P + 2] <= meas.fund_s;
				end
			end
			if (op_done && !op_sqrt) begin
				// Quotient is a magnitude; the sign is put back for factors
				res_q[op_dest] <= op_neg ? DW'(-div_quo) : div_quo;
			end
		end
	end

	heos_divider #(
		.NW (DW),
		.FW (FRAC)
	) u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (div_start),
		.num     (op_num),
		.den     (op_den),
		.done    (div_done),
		.quo     (div_quo)
	);

	heos_sqrt #(
		.RW (DW)
	) u_sqrt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (sqrt_start),
		.rad     (op_rad),
		.done    (sqrt_done),
		.root    (sqrt_root)
	);

	// ******************************************************
	// AXI4-Lite slave
	// ******************************************************
	logic          aw_held_q;
	logic          w_held_q;
	logic [AW-1:0] awaddr_q;
	logic [31:0]   wdata_q;
	logic [3:0]    wstrb_q;
	logic          bvalid_q;
	logic [1:0]    bresp_q;
	logic          rvalid_q;
	logic [1:0]    rresp_q;
	logic [31:0]   rdata_q;
	logic          awready;
	logic          wready;
	logic          arready;
	logic          do_write;
	logic          wr_ctrl;
	logic          wr_idx;
	logic [1:0]    wr_k;
	logic [31:0]   rd_data;
	logic          rd_ok;
	logic [AW-1:0] rd_off;

	assign awready  = !aw_held_q && !bvalid_q;
	assign wready   = !w_held_q && !bvalid_q;
	assign arready  = !rvalid_q;
	assign do_write = aw_held_q && w_held_q && !bvalid_q;
	assign wr_ctrl  = awaddr_q == ADDR_CTRL;
	assign wr_idx   = awaddr_q >= ADDR_IDX_BASE && awaddr_q < ADDR_STATUS
		&& awaddr_q[1:0] == 2'b00;
	assign wr_k     = 2'((awaddr_q - ADDR_IDX_BASE) >> 2);

	always_comb begin
		axil_rsp.awready = awready;
		axil_rsp.wready  = wready;
		axil_rsp.bresp   = bresp_q;
		axil_rsp.bvalid  = bvalid_q;
		axil_rsp.arready = arready;
		axil_rsp.rdata   = rdata_q;
		axil_rsp.rresp   = rresp_q;
		axil_rsp.rvalid  = rvalid_q;
	end

	// Write address and data may come in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (axil_req.awvalid && awready) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= axil_req.awaddr;
			end
			if (axil_req.wvalid && wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= axil_req.wdata;
				wstrb_q  <= axil_req.wstrb;
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (wr_ctrl || wr_idx) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && axil_req.bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_neutral_q <= CTRL_RST;
			idx_q          <= {NH{IDX_RST}};
		end else if (do_write && wstrb_q[0]) begin
			if (wr_ctrl) begin
				ctrl_neutral_q <= wdata_q[CTRL_NEUTRAL_BIT];
			end
			if (wr_idx) begin
				// Only six bits are held, so no index above 63 can exist
				idx_q[wr_k] <= wdata_q[IW-1:0];
			end
		end
	end

	always_comb begin
		rd_data = '0;
		rd_ok   = 1'b1;
		rd_off  = axil_req.araddr - ADDR_RES_BASE;
		if (axil_req.araddr[1:0] != 2'b00) begin
			rd_ok = 1'b0;
		end else if (axil_req.araddr == ADDR_CTRL) begin
			rd_data[CTRL_NEUTRAL_BIT] = ctrl_neutral_q;
		end else if (axil_req.araddr >= ADDR_IDX_BASE && axil_req.araddr < ADDR_STATUS) begin
			rd_data[IW-1:0] = idx_q[2'((axil_req.araddr - ADDR_IDX_BASE) >> 2)];
		end else if (axil_req.araddr == ADDR_STATUS) begin
			rd_data[STAT_BUSY_BIT]  = !meas_ready;
			rd_data[STAT_NDIST_BIT] = ndist_q;
			rd_data[STAT_MODE_BIT]  = mode_q;
		end else if (axil_req.araddr >= ADDR_RES_BASE && (rd_off >> 2) < AW'(NRES)) begin
			rd_data[DW-1:0] = res_q[5'(rd_off >> 2)];
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= '0;
		end else if (axil_req.arvalid && arready) begin
			rvalid_q <= 1'b1;
			rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			rdata_q  <= rd_data;
		end else if (rvalid_q && axil_req.rready) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule // heos_top

/* File: tb/heos_monitor.sv */
module heos_monitor import heos_pkg::*; (
	// Clock and reset
	input wire logic                  aclk,
	input wire logic                  aresetn,
	// Watched ports
	input wire heos_axil_req_t        axil_req,
	input wire heos_axil_rsp_t        axil_rsp,
	input wire logic                  meas_valid,
	input wire logic                  meas_ready,
	input wire logic [NH-1:0][IW-1:0] harm_index,
	input wire logic                  neutral_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire acc  = meas_valid && meas_ready;
	wire fund = harm_index[0] == IDX_FUND;
	wire aw_w = axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
	// A real run needs far more than eight cycles, so a skipped run shows at once
	sequence s_busy;
		!meas_ready [*8];
	endsequence
	sequence s_run;
		s_busy ##[1:1000] meas_ready;
	endsequence
	a_phase_run: assert property (acc && !neutral_mode |=> s_run)
		else $error("phase run length wrong");
	a_neutral_run: assert property (acc && neutral_mode && fund |=> s_run)
		else $error("neutral ratio run length wrong");
	a_neutral_skip: assert property (acc && neutral_mode && !fund |=> meas_ready)
		else $error("neutral run without fundamental went busy");
	a_read_answer: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
		else $error("read answer late");
	a_read_hold: assert property (axil_rsp.rvalid && !axil_req.rready |=>
		axil_rsp.rvalid && $stable(axil_rsp.rdata))
		else $error("read data not held");
	a_result_width: assert property (axil_rsp.rvalid |-> axil_rsp.rdata[31:24] == 8'h00)
		else $error("upper read byte not zero");
	a_write_answer: assert property (aw_w |=> ##1 axil_rsp.bvalid)
		else $error("write answer late");
	a_write_hold: assert property (axil_rsp.bvalid && !axil_req.bready |=>
		axil_rsp.bvalid && $stable(axil_rsp.bresp))
		else $error("write response not held");
	a_read_refuse: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
		else $error("address taken while answer pending");
endmodule // heos_monitor

bind heos_top heos_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req),
	.axil_rsp(axil_rsp), .meas_valid(meas_valid), .meas_ready(meas_ready),
	.harm_index(harm_index), .neutral_mode(neutral_mode));

/* File: tb/heos_bench.sv */
module heos_bench import heos_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  aclk;
	logic                  aresetn;
	heos_axil_req_t        req;
	heos_axil_rsp_t        rsp;
	heos_meas_t            m;
	logic                  mv;
	logic                  mr;
	logic [NH-1:0][IW-1:0] hi;
	logic                  nm;
	int                    bad_count = 0;
	int                    tests_run = 0;
	logic [33:0]           rq[$];
	logic [1:0]            wq[$];
	logic [DW-1:0]         ex[NRES];

	heos_top dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
		.meas(m), .meas_valid(mv), .meas_ready(mr), .harm_index(hi), .neutral_mode(nm));

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// ****************
	// Reference model
	// ****************
	function automatic logic [23:0] ab(input logic [23:0] x);
		return x[23] ? -x : x;
	endfunction
	function automatic logic [23:0] rat(input logic [23:0] n, input logic [23:0] d);
		logic [47:0] q;
		q = {3'h0, n, 21'h0} / {24'h0, d};
		return (d == 0 || {2'b0, n} >= {d, 2'b0}) ? RATIO_MAX : q[23:0];
	endfunction
	function automatic logic [23:0] pf(input logic [23:0] p, q, s);
		logic [23:0] r;
		r = rat(ab(p), ab(s));
		return (p[23] ^ q[23]) ? -r : r;
	endfunction
	function automatic logic [23:0] thd(input logic [23:0] t, input logic [23:0] f);
		logic [47:0] x;
		logic [23:0] r;
		logic [23:0] c;
		x = (ab(t) > ab(f)) ? 48'(ab(t)) * 48'(ab(t)) - 48'(ab(f)) * 48'(ab(f)) : 48'h0;
		r = 24'h0;
		for (int b = 23; b >= 0; b--) begin
			c = r | (24'h1 << b);
			if (48'(c) * 48'(c) <= x) r = c;
		end
		return rat(r, ab(f));
	endfunction
	function automatic logic [23:0] hr();
		return 24'($urandom & 32'h3FFFFF);
	endfunction
	function automatic logic [23:0] fr();
		return 24'h100000 | 24'($urandom & 32'hFFFFF);
	endfunction
	// Apparent power above any active magnitude keeps the factor out of saturation
	function automatic logic [23:0] sv();
		return 24'h400000 | hr();
	endfunction
	function automatic logic [23:0] sm();
		logic [23:0] v;
		v = hr();
		return $urandom % 2 ? -v : v;
	endfunction

	// ****************
	// Drivers and checking
	// ****************
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: got %h want %h", $time, g, e);
		end
	endtask
	always @(posedge aclk) begin
		if (rsp.rvalid === 1'b1 && req.rready === 1'b1) chk({rsp.rresp, rsp.rdata}, rq.pop_front());
		if (rsp.bvalid === 1'b1 && req.bready === 1'b1) chk(34'(rsp.bresp), 34'(wq.pop_front()));
	end
	// Response ready stays high between transfers, so back-to-back calls never
	// drop and raise it in one time step; a wait ends on the response, or at the watchdog if none comes
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		wq.push_back(r);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
			if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		rq.push_back({r, d});
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
	endtask
	task automatic sweep(input logic [31:0] st);
		rd(ADDR_STATUS, st, RESP_OKAY);
		for (int i = 0; i < NRES; i++) rd(ADDR_RES_BASE + AW'(4 * i), {8'h00, ex[i]}, RESP_OKAY);
	endtask
	task automatic gen(output heos_meas_t x);
		x.fund_p = sm();
		x.fund_q = 24'($urandom);
		x.fund_s = sv();
		x.fund_v_rms = fr();
		x.fund_i_rms = fr();
		x.v_rms = x.fund_v_rms + hr();
		x.i_rms = x.fund_i_rms + hr();
		for (int h = 0; h < NH; h++) begin
			x.harm_p[h] = sm();
			x.harm_q[h] = 24'($urandom);
			x.harm_s[h] = sv();
			x.harm_v_rms[h] = hr();
			x.harm_i_rms[h] = hr();
			x.neutral_rms[h] = fr();
			x.summed_phase_current[h] = fr();
		end
	endtask
	task automatic run(input heos_meas_t x);
		m <= x;
		mv <= 1'b1;
		@(posedge aclk);
		mv <= 1'b0;
		do begin
			@(posedge aclk);
		end while (mr !== 1'b1);
	endtask
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (10000) @(posedge aclk);
		bad_count++;
		complete_run();
	end

	initial begin
		heos_meas_t x;
		void'($urandom(90));
		aresetn = 1'b0;
		req = '0;
		m = '0;
		mv = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0, RESP_OKAY);
		wr(ADDR_IDX_BASE, 32'h2, RESP_OKAY);
		wr(ADDR_IDX_BASE + 8'h04, 32'h3, RESP_OKAY);
		wr(ADDR_IDX_BASE + 8'h08, 32'h3F, RESP_OKAY);
		rd(ADDR_IDX_BASE + 8'h08, 32'h3F, RESP_OKAY);
		chk(34'(hi), 34'({6'h3F, 6'h03, 6'h02}));
		wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
		rd(8'h20, 32'h0, RESP_SLVERR);
		rd(8'h41, 32'h0, RESP_SLVERR);
		gen(x);
		// Ratio above four must clamp
		x.harm_v_rms[0] = 24'h7FFFFF;
		ex[RES_FUND_P] = x.fund_p;
		ex[RES_FUND_P + 1] = x.fund_q;
		ex[RES_FUND_P + 2] = x.fund_s;
		ex[RES_FPF] = pf(x.fund_p, x.fund_q, x.fund_s);
		ex[RES_VOLTAGE_TOTAL_DISTORTION] = thd(x.v_rms, x.fund_v_rms);
		ex[RES_CURRENT_TOTAL_DISTORTION] = thd(x.i_rms, x.fund_i_rms);
		for (int h = 0; h < NH; h++) begin
			ex[RES_HARM_P + 3 * h] = x.harm_p[h];
			ex[RES_HARM_P + 3 * h + 1] = x.harm_q[h];
			ex[RES_HARM_P + 3 * h + 2] = x.harm_s[h];
			ex[RES_HPF + h] = pf(x.harm_p[h], x.harm_q[h], x.harm_s[h]);
			ex[RES_HVD + h] = rat(x.harm_v_rms[h], x.fund_v_rms);
			ex[RES_HID + h] = rat(x.harm_i_rms[h], x.fund_i_rms);
			ex[RES_HI_RMS + h] = x.harm_i_rms[h];
			ex[RES_HV_RMS + h] = x.harm_v_rms[h];
		end
		run(x);
		sweep(32'h0);
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		wr(ADDR_IDX_BASE, 32'h1, RESP_OKAY);
		chk(34'(nm), 34'h1);
		for (int k = 0; k < 2; k++) begin
			gen(x);
			for (int h = 0; h < NH; h++) begin
				ex[RES_HI_RMS + h] = x.neutral_rms[h];
				ex[RES_HV_RMS + h] = x.summed_phase_current[h];
				if (k == 0) ex[RES_HID + h] = rat(x.neutral_rms[h], x.neutral_rms[0]);
				if (k == 0) ex[RES_HVD + h] = rat(x.summed_phase_current[h], x.summed_phase_current[0]);
			end
			run(x);
			sweep(k == 0 ? 32'h6 : 32'h4);
			wr(ADDR_IDX_BASE, 32'h2, RESP_OKAY);
		end
		complete_run();
	end
endmodule // heos_bench
